/* hdl/sac_defines.vh */
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH
// Core clock period and conversion timing
`define SAC_CLK_PERIOD_NS 40
`define SAC_CONV_MAX_NS 853
`define SAC_CONV_TYP_NS 812
`define SAC_ACQ_MIN_NS 813
`define SAC_CYCLE_MIN_NS 1666
// Cycles from the pin edge to the core seeing it (two sync stages + edge detect)
`define SAC_SYNC_LAT 3
// Longest time rounds down to whole cycles
`define SAC_CONV_CYC (`SAC_CONV_MAX_NS / `SAC_CLK_PERIOD_NS)
`define SAC_CONV_RUN (`SAC_CONV_CYC - `SAC_SYNC_LAT)
`define SAC_CNT_W 5
// Result layout
`define SAC_DATA_W 16
`define SAC_MSB 15
// Serial clock falls that end a read
`define SAC_LAST_FALL_PLAIN 5'h10
`define SAC_LAST_FALL_BUSY 5'h11
`define SAC_ZERO_CNT 5'h00
`define SAC_ONE_CNT 5'h01
`endif

/* hdl/sac_sync.v */
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Two-stage synchroniser for one pin
module sac_sync (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_pin,
  output reg o_level
);
  reg meta;

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta <= i_pin;
      o_level <= meta;
    end
  end
endmodule // sac_sync
`default_nettype wire

/* hdl/sac_port.v */
// Behaviour
// - Convert-start rising edge samples serial_data_in to pick the mode for that cycle.
// - serial_data_in high (or tied to start) selects chip-select mode; low selects chain.
// - Result is ready no later than 853 ns after the convert-start rising edge.
// - Conversion runs on the internal clock; result is the current sample, no latency.
// - Sampled code is held through conversion; the input is ignored meanwhile.
// - After conversion the block returns to acquisition; host allows 813 ns.
// - Result is 16-bit straight binary, passed through unchanged.
// - Three-wire variant: convert-start doubles as read select.
// - Four-wire variant: serial_data_in acts as a separate read select.
// - Chain mode acts as one shift-register stage passing upstream data along.
// - Optional busy bit precedes the data in both modes.
// - Chip-select mode covers 3-wire and 4-wire, each with or without busy.
// - Convert-start rise samples, starts conversion and floats serial_data_out.
// - No busy: MSB at select fall, shift on falls, release at 16th fall or select rise.
// - Busy: low bit at end, then data; release at 17th fall or select rise.
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.vh"
module sac_port (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_cnv,
  input wire i_serial_data_in,
  input wire i_sck,
  input wire [15:0] i_sample_code,
  output reg o_serial_data_out,
  output reg o_serial_data_out_oe,
  output reg o_converting,
  output reg o_chain_mode,
  output reg o_busy_enabled
);
  // ===================================================================
  // States
  localparam [4:0] ST_ACQ = 5'b00001;
  localparam [4:0] ST_CONV = 5'b00010;
  localparam [4:0] ST_WAIT_SEL = 5'b00100;
  localparam [4:0] ST_SHIFT = 5'b01000;
  localparam [4:0] ST_CHAIN = 5'b10000;

  // ===================================================================
  // Conversion length
  // Whole core cycles left once the start edge has crossed the
  // synchroniser, cut on purpose to the counter width
  localparam integer CONV_RUN = `SAC_CONV_RUN;
  wire [31:0] conv_run_full = CONV_RUN;
  wire [`SAC_CNT_W-1:0] conv_run = conv_run_full[`SAC_CNT_W-1:0];

  // ===================================================================
  // Internal state
  wire cnv_s;
  wire sdi_s;
  wire sck_s;
  reg cnv_d;
  reg sck_d;
  reg sel_d;
  reg [4:0] state;
  reg [`SAC_CNT_W-1:0] conv_cnt;
  reg [`SAC_CNT_W-1:0] fall_cnt;
  reg [`SAC_CNT_W-1:0] last_fall;
  reg [`SAC_MSB:0] held;
  reg [`SAC_MSB:0] shreg;

  // ===================================================================
  // Pin synchronisers
  // Convert-start, data in and serial clock each cross two flip-flops before any logic reads them
  sac_sync u_sync_cnv (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_pin(i_cnv),
    .o_level(cnv_s)
  );
  sac_sync u_sync_sdi (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_pin(i_serial_data_in),
    .o_level(sdi_s)
  );
  sac_sync u_sync_sck (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_pin(i_sck),
    .o_level(sck_s)
  );

  // ===================================================================
  // Edge and select decode
  // Read select is low when either line is low: 3-wire keeps the data
  // input high, 4-wire keeps convert-start high during readout
  wire sel_n = cnv_s & sdi_s;
  wire cnv_rise = cnv_s & ~cnv_d;
  wire sck_fall = sck_d & ~sck_s;
  wire sel_fall = sel_d & ~sel_n;
  wire sel_rise = sel_n & ~sel_d;
  wire conv_done = (conv_cnt == `SAC_ONE_CNT);
  // Last counted fall of a read: 16th plain, 17th after the busy bit
  wire [`SAC_CNT_W-1:0] last_idx = last_fall - `SAC_ONE_CNT;
  wire read_last = sck_fall & (fall_cnt == last_idx);
  wire read_end = sel_rise | read_last;

  // ===================================================================
  // Edge history
  // Pins idle low, so clearing the history gives no false edge after reset
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnv_d <= 1'b0;
      sck_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      cnv_d <= cnv_s;
      sck_d <= sck_s;
      sel_d <= sel_n;
    end
  end

  // ===================================================================
  // Conversion and serial port sequencer
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_ACQ;
      conv_cnt <= `SAC_ZERO_CNT;
      fall_cnt <= `SAC_ZERO_CNT;
      last_fall <= `SAC_LAST_FALL_PLAIN;
      held <= {`SAC_DATA_W{1'b0}};
      shreg <= {`SAC_DATA_W{1'b0}};
      o_serial_data_out <= 1'b0;
      o_serial_data_out_oe <= 1'b0;
      o_converting <= 1'b0;
      o_chain_mode <= 1'b0;
      o_busy_enabled <= 1'b0;
    end else if (cnv_rise) begin
      // A new start always wins, aborting any read in progress
      state <= ST_CONV;
      held <= i_sample_code;
      conv_cnt <= conv_run;
      o_chain_mode <= ~sdi_s;
      // Chain mode: serial clock high at the start asks for busy
      o_busy_enabled <= sdi_s ? 1'b0 : sck_s;
      o_serial_data_out_oe <= 1'b0;
      o_serial_data_out <= 1'b0;
      o_converting <= 1'b1;
      fall_cnt <= `SAC_ZERO_CNT;
    end else begin
      case (state)
        ST_ACQ: begin
          // Idle chain stage pulls low while both inputs are low
          if (o_chain_mode && !sdi_s && !cnv_s) begin
            o_serial_data_out <= 1'b0;
            o_serial_data_out_oe <= 1'b1;
          end
        end
        ST_CONV: begin
          // Fixed count of internal clock cycles; only a new convert-start rise restarts it
          conv_cnt <= conv_cnt - `SAC_ONE_CNT;
          if (conv_done) begin
            o_converting <= 1'b0;
            shreg <= held;
            fall_cnt <= `SAC_ZERO_CNT;
            if (o_chain_mode) begin
              state <= ST_CHAIN;
              o_serial_data_out_oe <= 1'b1;
              o_serial_data_out <= o_busy_enabled ? sdi_s : held[`SAC_MSB];
              if (!o_busy_enabled) begin
                shreg <= {held[`SAC_MSB-1:0], 1'b0};
              end
            end else if (!sel_n) begin
              // Select low at the end: lead with the busy bit
              o_busy_enabled <= 1'b1;
              last_fall <= `SAC_LAST_FALL_BUSY;
              o_serial_data_out <= 1'b0;
              o_serial_data_out_oe <= 1'b1;
              state <= ST_SHIFT;
            end else begin
              // Select high at the end: the MSB waits for select to fall
              o_busy_enabled <= 1'b0;
              last_fall <= `SAC_LAST_FALL_PLAIN;
              state <= ST_WAIT_SEL;
            end
          end
        end
        ST_WAIT_SEL: begin
          // Plain read: MSB appears as soon as select falls
          if (sel_fall) begin
            o_serial_data_out <= held[`SAC_MSB];
            o_serial_data_out_oe <= 1'b1;
            shreg <= {held[`SAC_MSB-1:0], 1'b0};
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // Released at the last counted fall or as soon as select rises
          if (read_end) begin
            o_serial_data_out_oe <= 1'b0;
            o_serial_data_out <= 1'b0;
            state <= ST_ACQ;
          end else if (sck_fall) begin
            fall_cnt <= fall_cnt + `SAC_ONE_CNT;
            o_serial_data_out <= shreg[`SAC_MSB];
            shreg <= {shreg[`SAC_MSB-1:0], 1'b0};
          end
        end
        ST_CHAIN: begin
          // Upstream bit enters as our own bit leaves
          if (sck_fall) begin
            fall_cnt <= `SAC_ONE_CNT;
            o_serial_data_out <= shreg[`SAC_MSB];
            shreg <= {shreg[`SAC_MSB-1:0], sdi_s};
          end else if (o_busy_enabled && fall_cnt == `SAC_ZERO_CNT) begin
            // Until the first fall the busy bit repeats the upstream level
            o_serial_data_out <= sdi_s;
          end
        end
        default: begin
          state <= ST_ACQ;
        end
      endcase
    end
  end
endmodule // sac_port
`default_nettype wire

/* sim/sac_port_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module sac_port_checker (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_cnv,
  input wire i_serial_data_in,
  input wire i_sck,
  input wire [15:0] i_sample_code,
  input wire o_serial_data_out,
  input wire o_serial_data_out_oe,
  input wire o_converting,
  input wire o_chain_mode,
  input wire o_busy_enabled
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_flt; $rose(i_cnv) |-> ##[1:5] !o_serial_data_out_oe; endproperty
  a_flt: assert property (p_flt) else $error("output not floated");
  property p_go; $rose(i_cnv) |-> ##[2:5] $rose(o_converting); endproperty
  a_go: assert property (p_go) else $error("no conversion start");
  property p_end; $rose(i_cnv) |-> ##[17:21] $fell(o_converting); endproperty
  a_end: assert property (p_end) else $error("conversion too long");
  property p_mode; $rose(o_converting) |-> o_chain_mode == !i_serial_data_in; endproperty
  a_mode: assert property (p_mode) else $error("wrong mode");
  property p_hold; o_converting && $past(o_converting) |-> !o_serial_data_out_oe; endproperty
  a_hold: assert property (p_hold) else $error("driven in conversion");
  property p_rel;
    o_serial_data_out_oe && !o_chain_mode && $rose(i_cnv & i_serial_data_in)
      |-> ##[1:5] !o_serial_data_out_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("no release on select");
  property p_bsy;
    $rose(o_serial_data_out_oe) && o_busy_enabled && !o_chain_mode |-> !o_serial_data_out;
  endproperty
  a_bsy: assert property (p_bsy) else $error("busy bit not low");
  property p_chn; $fell(o_converting) && o_chain_mode |-> ##[0:2] o_serial_data_out_oe; endproperty
  a_chn: assert property (p_chn) else $error("chain not driving");
endmodule // sac_port_checker
`default_nettype wire

/* sim/sac_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sac_host (
  input wire logic i_core_clk,
  output var logic o_cnv,
  output var logic o_sdi,
  output var logic o_sck
);
  initial begin
    o_cnv = 1'b0;
    o_sdi = 1'b1;
    o_sck = 1'b0;
  end
  task automatic wclk(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Mode 0 chain, 1 three-wire, 2 four-wire; with busy set, mode 2 selects with convert-start low, as mode 1 does
  task automatic convert(input logic [1:0] m, input logic b);
    o_sdi <= (m != 2'h0);
    o_sck <= b & (m == 2'h0);
    wclk(2);
    o_cnv <= 1'b1;
    wclk(4);
    if (b && m != 2'h0) o_cnv <= 1'b0;
    wclk(19);
    o_sck <= 1'b1;
    if (!b && m == 2'h1) o_cnv <= 1'b0;
    if (!b && m == 2'h2) o_sdi <= 1'b0;
    wclk(5);
  endtask
  task automatic tick;
    o_sck <= 1'b0;
    wclk(4);
    o_sck <= 1'b1;
    wclk(4);
  endtask
  // Four-wire select returns high to end a read early
  task automatic deselect;
    o_sdi <= 1'b1;
    wclk(6);
  endtask
  task automatic raise;
    o_cnv <= 1'b1;
    wclk(6);
  endtask
  // Clock stands low; spacing covers acquisition and cycle time
  task automatic idle;
    o_sck <= 1'b0;
    o_cnv <= 1'b0;
    o_sdi <= 1'b1;
    wclk(45);
  endtask
endmodule // sac_host
`default_nettype wire

/* sim/sac_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module sac_port_tb;
  typedef struct {logic [1:0] m; logic b; logic [15:0] c;} sac_row_t;
  logic clk, rstn, cnv, serial_data_in, sck, serial_data_out, oe, conv, chain, busy;
  logic [15:0] code;
  int error_cnt = 0;
  int checks = 0;
  sac_row_t rows [6] = '{'{2'h0, 1'h0, 16'h8000}, '{2'h0, 1'h1, 16'hffff},
    '{2'h1, 1'h0, 16'h0000}, '{2'h1, 1'h1, 16'h7fff},
    '{2'h2, 1'h0, 16'ha5a5}, '{2'h2, 1'h1, 16'h0001}};
  sac_port dut_u(.i_core_clk(clk), .i_resetn(rstn), .i_cnv(cnv), .i_serial_data_in(serial_data_in),
    .i_sck(sck), .i_sample_code(code), .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(oe),
    .o_converting(conv), .o_chain_mode(chain), .o_busy_enabled(busy));
  sac_host host_u(.i_core_clk(clk), .o_cnv(cnv), .o_sdi(serial_data_in), .o_sck(sck));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic frame(input logic [1:0] m, input logic b, input logic [15:0] c);
    logic [16:0] e;
    e = {1'b0, c};
    code <= c;
    fork
      host_u.convert(m, b);
      begin
        repeat (8) @(posedge clk);
        code <= ~c;
      end
    join
    cmp({14'h0, chain, busy}, {14'h0, m == 2'h0, b});
    for (int i = 15 + b; i >= 0; i--) begin
      cmp({14'h0, oe, serial_data_out}, {14'h0, 1'b1, e[i]});
      host_u.tick();
    end
    if (m != 2'h0) cmp({15'h0, oe}, 16'h0);
    host_u.idle();
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    code = 16'h0;
    repeat (4) @(posedge clk);
    cmp({14'h0, oe, conv}, 16'h0);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (rows[k]) frame(rows[k].m, rows[k].b, rows[k].c);
    host_u.convert(2'h1, 1'b0);
    repeat (2) host_u.tick();
    host_u.raise();
    cmp({15'h0, oe}, 16'h0);
    host_u.idle();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({11'h0, oe, serial_data_out, conv, chain, busy}, 16'h0);
    rstn <= 1'b1;
    @(posedge clk);
    frame(2'h1, 1'b0, 16'h1234);
    host_u.convert(2'h2, 1'b0);
    repeat (2) host_u.tick();
    host_u.deselect();
    cmp({15'h0, oe}, 16'h0);
    host_u.idle();
    finish_test();
  end
endmodule // sac_port_tb
bind sac_port sac_port_checker chk_u(.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_cnv(i_cnv), .i_serial_data_in(i_serial_data_in), .i_sck(i_sck),
  .i_sample_code(i_sample_code), .o_serial_data_out(o_serial_data_out),
  .o_serial_data_out_oe(o_serial_data_out_oe), .o_converting(o_converting),
  .o_chain_mode(o_chain_mode), .o_busy_enabled(o_busy_enabled));
`default_nettype wire
